// file: hdl/compare_rotate_status_unit.sv
// Purpose: Compare, rotate and status transfer datapath slice
// Assumes: Decoder supplies op, first byte and operand; register file is outside
// Notes: Each instruction runs a fixed number of clocks, then retires once
`timescale 1ns/10ps
module compare_rotate_status_unit #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire crs_pkg::request_s request_i,
  input wire logic indexed_i,
  input wire logic [WIDTH-1:0] selected_reg_i,
  input wire logic [WIDTH-1:0] reg_zero_i,
  output logic busy_o,
  output logic done_o,
  output crs_pkg::writeback_s writeback_o,
  output logic [WIDTH-1:0] upper_status_byte_o,
  output logic [WIDTH-1:0] lower_status_byte_o
);
  // ==========================================================
  // Request capture and instruction timer
  // ==========================================================
  crs_pkg::request_s held;
  logic held_indexed;
  logic [WIDTH-1:0] held_sel;
  logic [WIDTH-1:0] held_zero;
  logic [3:0] count;
  logic [3:0] length;
  logic finish;

  // Operands are latched so a changing register file cannot skew the result
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      held <= '0;
      held_indexed <= 1'b0;
      held_sel <= '0;
      held_zero <= '0;
    end
    else if (start_i && !busy_o)
    begin
      held <= request_i;
      held_indexed <= indexed_i;
      held_sel <= selected_reg_i;
      held_zero <= reg_zero_i;
    end
  end

  // Length by instruction class
  always_comb
  begin
    case (request_i.op)
      crs_pkg::OP_COMPARE_RELATIVE,
      crs_pkg::OP_PRESET_UPPER_STATUS: length = crs_pkg::LONG_CLOCKS;
      default: length = crs_pkg::SHORT_CLOCKS;
    endcase
  end

  // Down counter; busy while nonzero, retire on the last clock
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      count <= 4'h0;
    else if (start_i && !busy_o && request_i.op != crs_pkg::OP_NONE)
      count <= length;
    else if (count != 4'h0)
      count <= count - 4'h1;
  end

  assign busy_o = (count != 4'h0);
  assign finish = (count == 4'h1);

  // ==========================================================
  // Compare
  // ==========================================================
  logic is_compare;
  logic [WIDTH-1:0] cmp_left;
  logic [WIDTH-1:0] cmp_right;
  logic [1:0] cmp_code;

  assign is_compare = held.op == crs_pkg::OP_COMPARE_REG ||
                      held.op == crs_pkg::OP_COMPARE_IMMEDIATE ||
                      held.op == crs_pkg::OP_COMPARE_RELATIVE ||
                      held.op == crs_pkg::OP_COMPARE_ABSOLUTE;

  // Left operand: register zero for register form and indexed absolute
  always_comb
  begin
    cmp_left = held_sel;
    cmp_right = held.operand;
    if (held.op == crs_pkg::OP_COMPARE_REG)
    begin
      cmp_left = held_zero;
      cmp_right = held_sel;
    end
    else if (held.op == crs_pkg::OP_COMPARE_ABSOLUTE && held_indexed)
      cmp_left = held_zero;
  end

  crs_compare #(
    .WIDTH(WIDTH)
  ) compare_unit (
    .left_i(cmp_left),
    .right_i(cmp_right),
    .unsigned_mode_i(lower_status_byte_o[crs_pkg::LSB_COM]),
    .code_o(cmp_code)
  );

  // ==========================================================
  // Rotate
  // ==========================================================
  logic with_carry_bit;
  logic old_carry;
  logic [WIDTH-1:0] rot_value;
  logic rot_carry;
  logic rot_idc;

  assign with_carry_bit = lower_status_byte_o[crs_pkg::LSB_WC];
  assign old_carry = lower_status_byte_o[crs_pkg::LSB_C];

  // Rotated value and carry-chain side effects
  always_comb
  begin
    rot_value = held_sel;
    rot_carry = old_carry;
    rot_idc = lower_status_byte_o[crs_pkg::LSB_IDC];
    if (held.op == crs_pkg::OP_ROTATE_LEFT)
    begin
      if (with_carry_bit)
      begin
        rot_value = {held_sel[WIDTH-2:0], old_carry};
        rot_carry = held_sel[WIDTH-1];
        rot_idc = held_sel[4];
      end
      else
        rot_value = {held_sel[WIDTH-2:0], held_sel[WIDTH-1]};
    end
    else if (held.op == crs_pkg::OP_ROTATE_RIGHT)
    begin
      if (with_carry_bit)
      begin
        rot_value = {old_carry, held_sel[WIDTH-1:1]};
        rot_carry = held_sel[0];
        rot_idc = held_sel[6];
      end
      else
        rot_value = {held_sel[0], held_sel[WIDTH-1:1]};
    end
  end

  // Sign and zero classification of a byte
  function automatic logic [1:0] classify(input logic [WIDTH-1:0] value);
    if (value[WIDTH-1])
      return crs_pkg::CC_NEGATIVE;
    else if (value == '0)
      return crs_pkg::CC_ZERO;
    else
      return crs_pkg::CC_POSITIVE;
  endfunction

  // ==========================================================
  // Status bytes
  // ==========================================================
  logic [WIDTH-1:0] next_upper;
  logic [WIDTH-1:0] next_lower;
  logic [WIDTH-1:0] upper_clean;

  assign upper_clean = upper_status_byte_o & crs_pkg::UPPER_USED_MASK;

  // New status values, committed on the retiring clock
  always_comb
  begin
    next_upper = upper_status_byte_o;
    next_lower = lower_status_byte_o;
    case (held.op)
      crs_pkg::OP_COMPARE_REG,
      crs_pkg::OP_COMPARE_IMMEDIATE,
      crs_pkg::OP_COMPARE_RELATIVE,
      crs_pkg::OP_COMPARE_ABSOLUTE:
        next_lower[crs_pkg::LSB_CC_HI:crs_pkg::LSB_CC_LO] = cmp_code;
      crs_pkg::OP_ROTATE_LEFT,
      crs_pkg::OP_ROTATE_RIGHT:
      begin
        next_lower[crs_pkg::LSB_CC_HI:crs_pkg::LSB_CC_LO] = classify(rot_value);
        next_lower[crs_pkg::LSB_C] = rot_carry;
        next_lower[crs_pkg::LSB_IDC] = rot_idc;
        if (rot_value[WIDTH-1] != held_sel[WIDTH-1])
          next_lower[crs_pkg::LSB_OVF] = 1'b1;
      end
      crs_pkg::OP_LOAD_UPPER_STATUS:
        next_upper = held_zero & crs_pkg::UPPER_USED_MASK;
      crs_pkg::OP_LOAD_LOWER_STATUS:
        next_lower = held_zero;
      crs_pkg::OP_STORE_UPPER_STATUS:
        next_lower[crs_pkg::LSB_CC_HI:crs_pkg::LSB_CC_LO] = classify(upper_clean);
      crs_pkg::OP_STORE_LOWER_STATUS:
        next_lower[crs_pkg::LSB_CC_HI:crs_pkg::LSB_CC_LO] =
          classify(lower_status_byte_o);
      crs_pkg::OP_PRESET_UPPER_STATUS:
        next_upper = (upper_status_byte_o | held.operand) & crs_pkg::UPPER_USED_MASK;
      default:
      begin
        next_upper = upper_status_byte_o;
        next_lower = lower_status_byte_o;
      end
    endcase
  end

  // Flags commit on the last clock, so they lead the next start
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      upper_status_byte_o <= crs_pkg::UPPER_RESET;
      lower_status_byte_o <= crs_pkg::LOWER_RESET;
    end
    else if (finish)
    begin
      upper_status_byte_o <= next_upper;
      lower_status_byte_o <= next_lower;
    end
  end

  // ==========================================================
  // Register writeback and completion
  // ==========================================================
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      writeback_o <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= finish;
      writeback_o.write <= 1'b0;
      if (finish)
      begin
        case (held.op)
          crs_pkg::OP_ROTATE_LEFT,
          crs_pkg::OP_ROTATE_RIGHT:
          begin
            writeback_o.write <= 1'b1;
            writeback_o.index <= held.first_byte[1:0];
            writeback_o.data <= rot_value;
          end
          crs_pkg::OP_STORE_UPPER_STATUS:
          begin
            writeback_o.write <= 1'b1;
            writeback_o.index <= 2'h0;
            writeback_o.data <= upper_clean;
          end
          crs_pkg::OP_STORE_LOWER_STATUS:
          begin
            writeback_o.write <= 1'b1;
            writeback_o.index <= 2'h0;
            writeback_o.data <= lower_status_byte_o;
          end
          default:
            writeback_o.write <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_compare_only_cc: assert property (@(posedge clock_i) disable iff (reset_i)
    (finish && is_compare) |=> !writeback_o.write &&
      upper_status_byte_o == $past(upper_status_byte_o) &&
      lower_status_byte_o[5:0] == $past(lower_status_byte_o[5:0]))
    else $error("compare changed more than the condition code");

  a_short_length: assert property (@(posedge clock_i) disable iff (reset_i)
    (start_i && !busy_o && request_i.op == crs_pkg::OP_ROTATE_LEFT) |=>
      busy_o [*6] ##1 !busy_o)
    else $error("short instruction not six clocks");

  a_long_length: assert property (@(posedge clock_i) disable iff (reset_i)
    (start_i && !busy_o && request_i.op == crs_pkg::OP_PRESET_UPPER_STATUS) |=>
      busy_o [*8] ##1 busy_o ##1 !busy_o)
    else $error("long instruction not nine clocks");

  a_rotate_ovf: assert property (@(posedge clock_i) disable iff (reset_i)
    (finish && (held.op == crs_pkg::OP_ROTATE_LEFT || held.op == crs_pkg::OP_ROTATE_RIGHT)
      && rot_value[7] != held_sel[7]) |=> lower_status_byte_o[crs_pkg::LSB_OVF])
    else $error("rotate overflow not set");

  a_rotate_idc: assert property (@(posedge clock_i) disable iff (reset_i)
    (finish && held.op == crs_pkg::OP_ROTATE_LEFT && with_carry_bit) |=>
      lower_status_byte_o[crs_pkg::LSB_IDC] == $past(held_sel[4]))
    else $error("rotate left interdigit carry wrong");

  a_upper_unassigned: assert property (@(posedge clock_i) disable iff (reset_i)
    upper_status_byte_o[4:3] == 2'h0)
    else $error("unassigned upper status bits set");

  a_preset_sets: assert property (@(posedge clock_i) disable iff (reset_i)
    (finish && held.op == crs_pkg::OP_PRESET_UPPER_STATUS) |=>
      ((upper_status_byte_o & $past(held.operand) & crs_pkg::UPPER_USED_MASK) ==
       ($past(held.operand) & crs_pkg::UPPER_USED_MASK)))
    else $error("preset bit not set");

  a_done_follows: assert property (@(posedge clock_i) disable iff (reset_i)
    finish |=> done_o && !busy_o)
    else $error("done not one clock after retire");
endmodule

// file: hdl/crs_compare.sv
// Purpose: Three-way magnitude compare, signed or unsigned
// Assumes: Operands are 8-bit
// Notes: Purely combinational
`timescale 1ns/10ps
module crs_compare #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] left_i,
  input wire logic [WIDTH-1:0] right_i,
  input wire logic unsigned_mode_i,
  output logic [1:0] code_o
);
  logic [WIDTH-1:0] left_adj;
  logic [WIDTH-1:0] right_adj;

  // Flipping the sign bits turns an unsigned compare into a signed one
  always_comb
  begin
    left_adj = left_i;
    right_adj = right_i;
    if (!unsigned_mode_i)
    begin
      left_adj[WIDTH-1] = ~left_i[WIDTH-1];
      right_adj[WIDTH-1] = ~right_i[WIDTH-1];
    end
    if (left_adj > right_adj)
      code_o = crs_pkg::CC_POSITIVE;
    else if (left_adj == right_adj)
      code_o = crs_pkg::CC_ZERO;
    else
      code_o = crs_pkg::CC_NEGATIVE;
  end
endmodule

// file: hdl/crs_pkg.sv
// Purpose: Shared constants and types for the compare, rotate and status unit
// Assumes: 50 MHz processor clock, three clock periods per instruction cycle
// Notes: Status byte layouts follow the processor status word bit assignment
package crs_pkg;
  // Timing
  localparam int unsigned CLOCK_PERIOD_NS = 20;
  localparam int unsigned CLOCKS_PER_CYCLE = 3;
  localparam int unsigned SHORT_CYCLES = 2;
  localparam int unsigned LONG_CYCLES = 3;
  localparam logic [3:0] SHORT_CLOCKS = 4'(SHORT_CYCLES * CLOCKS_PER_CYCLE);
  localparam logic [3:0] LONG_CLOCKS = 4'(LONG_CYCLES * CLOCKS_PER_CYCLE);

  // Lower status byte field positions
  localparam int unsigned LSB_CC_HI = 7;
  localparam int unsigned LSB_CC_LO = 6;
  localparam int unsigned LSB_IDC = 5;
  localparam int unsigned LSB_RS = 4;
  localparam int unsigned LSB_WC = 3;
  localparam int unsigned LSB_OVF = 2;
  localparam int unsigned LSB_COM = 1;
  localparam int unsigned LSB_C = 0;

  // Upper status byte: bits 4 and 3 unassigned
  localparam logic [7:0] UPPER_USED_MASK = 8'he7;
  localparam logic [7:0] UPPER_RESET = 8'h00;
  localparam logic [7:0] LOWER_RESET = 8'h00;

  // Condition code encodings
  localparam logic [1:0] CC_POSITIVE = 2'h1;
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_NEGATIVE = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_COMPARE_REG = 4'h1,
    OP_COMPARE_IMMEDIATE = 4'h2,
    OP_COMPARE_RELATIVE = 4'h3,
    OP_COMPARE_ABSOLUTE = 4'h4,
    OP_ROTATE_LEFT = 4'h5,
    OP_ROTATE_RIGHT = 4'h6,
    OP_LOAD_UPPER_STATUS = 4'h7,
    OP_LOAD_LOWER_STATUS = 4'h8,
    OP_STORE_UPPER_STATUS = 4'h9,
    OP_STORE_LOWER_STATUS = 4'ha,
    OP_PRESET_UPPER_STATUS = 4'hb
  } op_e;

  // One instruction request
  typedef struct packed {
    op_e op;
    logic [7:0] first_byte;
    logic [7:0] operand;
  } request_s;

  // Register writeback produced by an instruction
  typedef struct packed {
    logic write;
    logic [1:0] index;
    logic [7:0] data;
  } writeback_s;
endpackage

// file: tb/tb_compare_rotate_status_unit.sv
// Purpose: Self-checking bench for the compare, rotate and status unit
// Assumes: One done pulse per request, status bytes zero after reset
// Notes: Bench keeps its own status model; corner cases first, then random ops
`timescale 1ns/10ps
module tb_compare_rotate_status_unit;
  // ==========================================================
  // Signals and model state
  logic clock_i;
  logic reset_i;
  logic start_i;
  crs_pkg::request_s request_i;
  logic indexed_i;
  logic [7:0] selected_reg_i;
  logic [7:0] reg_zero_i;
  logic busy_o;
  logic done_o;
  crs_pkg::writeback_s writeback_o;
  logic [7:0] upper_status_byte_o;
  logic [7:0] lower_status_byte_o;
  int fails;
  int checks;
  int cycles;
  logic [7:0] model_upper;
  logic [7:0] model_lower;

  compare_rotate_status_unit compare_rotate_status_unit_inst (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .start_i(start_i),
    .request_i(request_i),
    .indexed_i(indexed_i),
    .selected_reg_i(selected_reg_i),
    .reg_zero_i(reg_zero_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .writeback_o(writeback_o),
    .upper_status_byte_o(upper_status_byte_o),
    .lower_status_byte_o(lower_status_byte_o)
  );

  // ==========================================================
  // Clock, 20 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      close_out();
    end
  end

  // ==========================================================
  // Expectation helpers
  function automatic logic [1:0] cc_of(input logic [7:0] v);
    if (v == 8'h00) return crs_pkg::CC_ZERO;
    return v[7] ? crs_pkg::CC_NEGATIVE : crs_pkg::CC_POSITIVE;
  endfunction

  // Three-way compare, unsigned when the mode bit is set
  function automatic logic [1:0] cmp3(input logic [7:0] a, input logic [7:0] b, input logic uns);
    if (a == b) return crs_pkg::CC_ZERO;
    if (uns ? (a > b) : ($signed(a) > $signed(b))) return crs_pkg::CC_POSITIVE;
    return crs_pkg::CC_NEGATIVE;
  endfunction

  // ==========================================================
  // Compare tasks and verdict
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if (got != exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // One instruction: update model, drive, wait for done, compare
  task automatic run_op(input crs_pkg::op_e op, input logic [7:0] fb, input logic [7:0] opd,
      input logic idx, input logic [7:0] sel, input logic [7:0] r0, input logic hold);
    logic [7:0] res;
    logic [7:0] wb_d;
    logic [1:0] wb_i;
    logic wb_w;
    logic left;
    int n;
    int k;
    wb_w = 1'b0;
    wb_d = 8'h00;
    wb_i = fb[1:0];
    n = crs_pkg::SHORT_CLOCKS;
    left = (op == crs_pkg::OP_ROTATE_LEFT);
    case (op)
      crs_pkg::OP_COMPARE_REG: model_lower[7:6] = cmp3(r0, sel, model_lower[1]);
      crs_pkg::OP_COMPARE_IMMEDIATE: model_lower[7:6] = cmp3(sel, opd, model_lower[1]);
      crs_pkg::OP_COMPARE_RELATIVE:
      begin
        model_lower[7:6] = cmp3(sel, opd, model_lower[1]);
        n = crs_pkg::LONG_CLOCKS;
      end
      crs_pkg::OP_COMPARE_ABSOLUTE:
      begin
        model_lower[7:6] = cmp3(idx ? r0 : sel, opd, model_lower[1]);
        n = 0; // Absolute timing is not pinned down, so not checked
      end
      crs_pkg::OP_ROTATE_LEFT, crs_pkg::OP_ROTATE_RIGHT:
      begin
        if (left)
          res = {sel[6:0], model_lower[3] ? model_lower[0] : sel[7]};
        else
          res = {model_lower[3] ? model_lower[0] : sel[0], sel[7:1]};
        if (model_lower[3])
        begin
          model_lower[0] = left ? sel[7] : sel[0];
          model_lower[5] = left ? sel[4] : sel[6];
        end
        if (res[7] != sel[7])
          model_lower[2] = 1'b1;
        model_lower[7:6] = cc_of(res);
        wb_w = 1'b1;
        wb_d = res;
      end
      crs_pkg::OP_LOAD_UPPER_STATUS: model_upper = r0 & crs_pkg::UPPER_USED_MASK;
      crs_pkg::OP_LOAD_LOWER_STATUS: model_lower = r0;
      crs_pkg::OP_STORE_UPPER_STATUS, crs_pkg::OP_STORE_LOWER_STATUS:
      begin
        wb_w = 1'b1;
        wb_i = 2'h0;
        if (op == crs_pkg::OP_STORE_UPPER_STATUS)
          wb_d = model_upper & crs_pkg::UPPER_USED_MASK;
        else
          wb_d = model_lower;
        model_lower[7:6] = cc_of(wb_d);
      end
      default:
      begin
        model_upper = model_upper | (opd & crs_pkg::UPPER_USED_MASK);
        n = crs_pkg::LONG_CLOCKS;
      end
    endcase
    @(posedge clock_i);
    start_i <= 1'b1;
    request_i <= '{op: op, first_byte: fb, operand: opd};
    indexed_i <= idx;
    selected_reg_i <= sel;
    reg_zero_i <= r0;
    @(posedge clock_i);
    start_i <= hold;
    // A refused request while busy must leave no trace
    if (hold)
    begin
      request_i <= '{op: crs_pkg::OP_PRESET_UPPER_STATUS, first_byte: 8'hff, operand: 8'hff};
      selected_reg_i <= ~sel;
    end
    k = 0;
    while (done_o !== 1'b1 && k < 15)
    begin
      @(posedge clock_i);
      if (k == 2)
        start_i <= 1'b0;
      k++;
      #1;
    end
    if (n != 0)
      chk_cnt(k, n);
    chk_byte({7'h00, busy_o}, 8'h00);
    chk_byte(upper_status_byte_o, model_upper);
    chk_byte(lower_status_byte_o, model_lower);
    chk_byte({7'h00, writeback_o.write}, {7'h00, wb_w});
    if (wb_w)
    begin
      chk_byte(writeback_o.data, wb_d);
      chk_byte({6'h00, writeback_o.index}, {6'h00, wb_i});
    end
  endtask

  // ==========================================================
  // Main sequence: reset, corner cases, then random traffic
  initial
  begin
    fails = 0;
    checks = 0;
    cycles = 0;
    reset_i = 1'b1;
    start_i = 1'b0;
    request_i = '0;
    indexed_i = 1'b0;
    selected_reg_i = 8'h00;
    reg_zero_i = 8'h00;
    model_upper = crs_pkg::UPPER_RESET;
    model_lower = crs_pkg::LOWER_RESET;
    void'($urandom(32'h3a02));
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk_byte(upper_status_byte_o, model_upper);
    chk_byte(lower_status_byte_o, model_lower);
    run_op(crs_pkg::OP_COMPARE_REG, 8'h01, 8'h00, 1'b0, 8'hff, 8'h01, 1'b0);
    run_op(crs_pkg::OP_LOAD_LOWER_STATUS, 8'h00, 8'h00, 1'b0, 8'h00, 8'h02, 1'b0);
    run_op(crs_pkg::OP_COMPARE_REG, 8'h02, 8'h00, 1'b0, 8'hff, 8'h01, 1'b0);
    run_op(crs_pkg::OP_COMPARE_IMMEDIATE, 8'h03, 8'h80, 1'b0, 8'h80, 8'h00, 1'b1);
    run_op(crs_pkg::OP_COMPARE_RELATIVE, 8'h01, 8'h80, 1'b0, 8'h7f, 8'h00, 1'b0);
    run_op(crs_pkg::OP_COMPARE_ABSOLUTE, 8'h02, 8'hfe, 1'b1, 8'h00, 8'hff, 1'b0);
    run_op(crs_pkg::OP_ROTATE_LEFT, 8'h01, 8'h00, 1'b0, 8'h80, 8'h00, 1'b0);
    run_op(crs_pkg::OP_LOAD_LOWER_STATUS, 8'h00, 8'h00, 1'b0, 8'h00, 8'h09, 1'b0);
    run_op(crs_pkg::OP_ROTATE_LEFT, 8'h02, 8'h00, 1'b0, 8'h10, 8'h00, 1'b0);
    run_op(crs_pkg::OP_ROTATE_RIGHT, 8'h03, 8'h00, 1'b0, 8'h41, 8'h00, 1'b0);
    run_op(crs_pkg::OP_LOAD_UPPER_STATUS, 8'h00, 8'h00, 1'b0, 8'h00, 8'hff, 1'b0);
    run_op(crs_pkg::OP_STORE_UPPER_STATUS, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    run_op(crs_pkg::OP_STORE_LOWER_STATUS, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    run_op(crs_pkg::OP_LOAD_UPPER_STATUS, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    run_op(crs_pkg::OP_PRESET_UPPER_STATUS, 8'h00, 8'h81, 1'b0, 8'h00, 8'h00, 1'b0);
    run_op(crs_pkg::OP_PRESET_UPPER_STATUS, 8'h00, 8'h18, 1'b0, 8'h00, 8'h00, 1'b0);
    // Random mix; random lower loads toggle the mode and with-carry bits
    for (int i = 0; i < 300; i++)
    begin
      run_op(crs_pkg::op_e'(4'($urandom_range(11, 1))), 8'($urandom), 8'($urandom),
        1'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
    end
    close_out();
  end
endmodule
